// File: spr_pkg.sv
package spr_pkg;
   // System clock rate
   localparam int CLK_MHZ = 100;
   // Least supply-to-select wait, in microseconds, and in cycles
   localparam int SEL_DELAY_US = 70;
   localparam int SEL_DELAY_CYC = SEL_DELAY_US * CLK_MHZ;
   // Longest power-up wait before program or erase, in milliseconds, and in cycles
   localparam int WR_DELAY_MS = 20;
   localparam int WR_DELAY_CYC = (WR_DELAY_MS * 1000 * CLK_MHZ);
   // Width of the power-up wait counters
   localparam int DLY_W = 22;
   // Instruction width and bit counter width
   localparam int OP_W = 8;
   localparam int BIT_W = 3;
   // Clock modes picked at each select
   localparam logic MODE_0 = 1'b0;
   localparam logic MODE_3 = 1'b1;
   // Default mode after power-up or reset
   localparam logic MODE_RST = MODE_3;
   // Serial output idle value and opcode reset value
   localparam logic SO_RST = 1'b0;
   localparam logic [OP_W-1:0] OP_RST = 8'h00;
   // Front end states
   typedef enum logic [1:0] {
      SPR_POR,
      SPR_STANDBY,
      SPR_SELECTED
   } spr_state_t;
endpackage

// File: spr_por_state.sv
// Function
// RULE1: After power-up or reset the front end takes clock mode 3 until a select picks another.
// RULE2: After power-up or reset the serial output stays undriven until a command asks for data.
// RULE3: An instruction is only taken after a falling chip select seen after power-up or reset.
// RULE4: Each falling chip select samples the idle serial clock level to pick mode 0 or mode 3.
// RULE5: A low clock at the falling chip select means mode 0, a high clock means mode 3.
// RULE6: While the supply is below the power-on reset threshold all commands are ignored.
// RULE7: The host waits 70 us after the supply reaches its minimum before selecting the part.
// RULE8: The host waits up to 20 ms after the threshold before program or erase is allowed.
// RULE9: Once power-up completes the front end rests in standby, not deep power-down.
module spr_por_state #(
   parameter int SEL_CYC = spr_pkg::SEL_DELAY_CYC,
   parameter int WR_CYC = spr_pkg::WR_DELAY_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Supply monitor levels (asynchronous)
   input wire logic vcc_min_ok,
   input wire logic por_thresh_ok,
   // Serial pins from the host (asynchronous)
   input wire logic cs_b_pin,
   input wire logic sck_pin,
   input wire logic si_pin,
   // Output data request from the command core
   input wire logic out_req,
   input wire logic out_bit,
   // Serial output pin
   output logic so_o,
   output logic so_oe,
   // Front end status
   output logic mode3_o,
   output logic standby_o,
   output logic sel_ready_o,
   output logic wr_ready_o,
   // Received instruction
   output logic cmd_valid_o,
   output logic [spr_pkg::OP_W-1:0] cmd_op_o
);
   import spr_pkg::*;

   logic cs_b_m_r, cs_b_s_r, cs_b_d_r;
   logic sck_m_r, sck_s_r, sck_d_r;
   logic si_m_r, si_s_r;
   logic vmin_m_r, vmin_s_r;
   logic por_m_r, por_s_r;
   logic cs_fall, cs_rise, sck_rise, sck_fall;
   spr_state_t state_r;
   logic armed_r;
   logic [BIT_W-1:0] bit_cnt_r;
   logic [OP_W-1:0] shift_r;
   logic [DLY_W-1:0] sel_cnt_r, wr_cnt_r;
   localparam logic [DLY_W-1:0] SEL_LIM = DLY_W'(SEL_CYC);
   localparam logic [DLY_W-1:0] WR_LIM = DLY_W'(WR_CYC);

   // Two-flop synchronisers; select flops reset to selected so a held select is no edge
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         {cs_b_m_r, cs_b_s_r, sck_m_r, sck_s_r, si_m_r, si_s_r} <= 6'h00;
         {vmin_m_r, vmin_s_r, por_m_r, por_s_r} <= 4'h0;
      end else begin
         cs_b_m_r <= cs_b_pin;
         cs_b_s_r <= cs_b_m_r;
         sck_m_r <= sck_pin;
         sck_s_r <= sck_m_r;
         si_m_r <= si_pin;
         si_s_r <= si_m_r;
         vmin_m_r <= vcc_min_ok;
         vmin_s_r <= vmin_m_r;
         por_m_r <= por_thresh_ok;
         por_s_r <= por_m_r;
      end
   end

   // Edge history, read only from the second flops
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cs_b_d_r <= 1'b0;
         sck_d_r <= 1'b0;
      end else begin
         cs_b_d_r <= cs_b_s_r;
         sck_d_r <= sck_s_r;
      end
   end

   // Select edges from the synced active-low pin, clock edges from the synced level
   assign cs_fall = ~cs_b_s_r & cs_b_d_r;
   assign cs_rise = cs_b_s_r & ~cs_b_d_r;
   assign sck_rise = sck_s_r & ~sck_d_r;
   assign sck_fall = ~sck_s_r & sck_d_r;

   // Front end state: held in reset below threshold, standby when idle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= SPR_POR;
      end else begin
         case (state_r)
            SPR_POR: if (por_s_r) state_r <= SPR_STANDBY; // [RULE9]
            SPR_STANDBY: if (!por_s_r) state_r <= SPR_POR; // [RULE6]
               else if (cs_fall) state_r <= SPR_SELECTED; // [RULE3]
            SPR_SELECTED: if (!por_s_r) state_r <= SPR_POR;
               else if (cs_b_s_r) state_r <= SPR_STANDBY;
            default: state_r <= SPR_POR;
         endcase
      end
   end

   // Armed only by a falling select seen outside power-on reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         armed_r <= 1'b0;
      end else if (!por_s_r || cs_rise) begin
         armed_r <= 1'b0; // [RULE6]
      end else if (cs_fall) begin
         armed_r <= 1'b1; // [RULE3]
      end
   end

   // Mode picked from the idle clock at each falling select outside power-on reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mode3_o <= MODE_RST; // [RULE1]
      end else if (!por_s_r) begin
         mode3_o <= MODE_RST; // [RULE1]
      end else if (cs_fall) begin
         mode3_o <= sck_s_r ? MODE_3 : MODE_0; // [RULE4] [RULE5]
      end
   end

   // Instruction shifter, data taken on rising clock in either mode
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bit_cnt_r <= '0;
         shift_r <= OP_RST;
         cmd_valid_o <= 1'b0;
         cmd_op_o <= OP_RST;
      end else begin
         cmd_valid_o <= 1'b0;
         if (cs_fall || !armed_r) begin
            bit_cnt_r <= '0;
         end else if (sck_rise && state_r == SPR_SELECTED) begin
            shift_r <= {shift_r[OP_W-2:0], si_s_r};
            bit_cnt_r <= bit_cnt_r + 1'b1;
            if (bit_cnt_r == BIT_W'(OP_W - 1) && por_s_r) begin
               cmd_valid_o <= 1'b1; // [RULE3] [RULE6]
               cmd_op_o <= {shift_r[OP_W-2:0], si_s_r};
            end
         end
      end
   end

   // Serial output driven only on request inside an armed select
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         so_o <= SO_RST;
         so_oe <= 1'b0; // [RULE2]
      end else begin
         so_oe <= armed_r && !cs_b_s_r && por_s_r && out_req; // [RULE2]
         if (sck_fall && armed_r && out_req) begin
            so_o <= out_bit;
         end
      end
   end

   // Standby flag
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         standby_o <= 1'b0;
      end else begin
         standby_o <= (state_r == SPR_STANDBY); // [RULE9]
      end
   end

   // Supply-to-select wait
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sel_cnt_r <= '0;
         sel_ready_o <= 1'b0;
      end else if (!vmin_s_r) begin
         sel_cnt_r <= '0;
         sel_ready_o <= 1'b0;
      end else if (sel_cnt_r != SEL_LIM) begin
         sel_cnt_r <= sel_cnt_r + 1'b1;
      end else begin
         sel_ready_o <= 1'b1; // [RULE7]
      end
   end

   // Threshold-to-write wait; program and erase are allowed only after it
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wr_cnt_r <= '0;
         wr_ready_o <= 1'b0;
      end else if (!por_s_r) begin
         wr_cnt_r <= '0;
         wr_ready_o <= 1'b0;
      end else if (wr_cnt_r != WR_LIM) begin
         wr_cnt_r <= wr_cnt_r + 1'b1;
      end else begin
         wr_ready_o <= 1'b1; // [RULE8]
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   a_mode_por_default: assert property (!por_s_r |=> mode3_o == MODE_3) // [RULE1]
      else $error("mode not 3 during power-on reset");
   a_so_idle_unarmed: assert property (!armed_r |=> !so_oe) // [RULE2]
      else $error("output driven without armed select");
   a_cmd_needs_arm: assert property (cmd_valid_o |-> // [RULE3]
      $past(armed_r) && $past(state_r) == SPR_SELECTED)
      else $error("command taken without select edge");
   a_mode_sample: assert property (cs_fall && por_s_r |=> mode3_o == $past(sck_s_r)) // [RULE4]
      else $error("mode not taken from idle clock");
   a_mode0_low: assert property (cs_fall && por_s_r && !sck_s_r |=> mode3_o == MODE_0) // [RULE5]
      else $error("low idle clock did not pick mode 0");
   a_por_ignore: assert property (!por_s_r |=> !cmd_valid_o && !armed_r) // [RULE6]
      else $error("command accepted during power-on reset");
   a_standby_after: assert property (state_r == SPR_POR && por_s_r |=> ##1 standby_o) // [RULE9]
      else $error("no standby after power-up");
   a_write_gate: assert property (wr_ready_o |-> // [RULE8]
      $past(por_s_r) && $past(wr_cnt_r) == WR_LIM)
      else $error("write allowed before wait ended");
   a_select_gate: assert property ($rose(sel_ready_o) |-> sel_cnt_r == SEL_LIM) // [RULE7]
      else $error("select ready before wait ended");
endmodule

// File: spr_host_model.sv
module spr_host_model (
   // Clock
   input wire logic clk_sys,
   // Serial pins to the device
   output logic cs_b_pin,
   output logic sck_pin,
   output logic si_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle and deselected; no program or erase work is ever sent
   initial begin
      cs_b_pin = 1'b1;
      sck_pin = 1'b1;
      si_pin = 1'b0;
   end
   // One framed byte, MSB first; the idle clock level picks the mode
   task automatic xfer(input logic m3, input logic [7:0] op);
      sck_pin <= m3;
      repeat (4) @(posedge clk_sys);
      cs_b_pin <= 1'b0;
      repeat (4) @(posedge clk_sys);
      shift_byte(op);
      sck_pin <= m3;
      repeat (4) @(posedge clk_sys);
      cs_b_pin <= 1'b1;
      si_pin <= ~si_pin; // Released line shows no stale bit
      repeat (4) @(posedge clk_sys);
   endtask
   // Eight clocks, MSB first, with the select left as it stands
   task automatic shift_byte(input logic [7:0] op);
      for (int i = 7; i >= 0; i--) begin
         si_pin <= op[i];
         sck_pin <= 1'b0;
         repeat (4) @(posedge clk_sys);
         sck_pin <= 1'b1;
         repeat (4) @(posedge clk_sys);
      end
   endtask
   // Move the select alone and let it settle
   task automatic set_select(input logic lvl);
      cs_b_pin <= lvl;
      repeat (4) @(posedge clk_sys);
   endtask
endmodule

// File: tb_spr_por_state.sv
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_spr_por_state;
   timeunit 1ns;
   timeprecision 1ps;
   import spr_pkg::*;
   logic clk_sys = 0, rst_b = 0, vcc_min_ok = 0, por_thresh_ok = 0, out_req = 0, out_bit = 0;
   logic cs_b_pin, sck_pin, si_pin, so_o, so_oe, mode3_o, standby_o;
   logic sel_ready_o, wr_ready_o, cmd_valid_o;
   logic [OP_W-1:0] cmd_op_o;
   int n_mismatch = 0, comparisons = 0, n_cmd = 0, cycles = 0;
   // Clock
   always #5 clk_sys = ~clk_sys;
   // Device and host
   spr_por_state #(.SEL_CYC(20), .WR_CYC(50)) spr_por_state_inst (.clk_sys(clk_sys),
      .rst_b(rst_b), .vcc_min_ok(vcc_min_ok), .por_thresh_ok(por_thresh_ok),
      .cs_b_pin(cs_b_pin), .sck_pin(sck_pin), .si_pin(si_pin), .out_req(out_req),
      .out_bit(out_bit), .so_o(so_o), .so_oe(so_oe), .mode3_o(mode3_o),
      .standby_o(standby_o), .sel_ready_o(sel_ready_o), .wr_ready_o(wr_ready_o),
      .cmd_valid_o(cmd_valid_o), .cmd_op_o(cmd_op_o));
   spr_host_model spr_host_model_inst (.clk_sys(clk_sys), .cs_b_pin(cs_b_pin),
      .sck_pin(sck_pin), .si_pin(si_pin));
   // Count instruction pulses and cut a hang short
   always @(posedge clk_sys) begin
      cycles++;
      if (cmd_valid_o === 1'b1) n_cmd++;
      if (cycles == 6000) begin
         n_mismatch++;
         results();
      end
   end
   task automatic results();
      if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic t_reset();
      `CHK(mode3_o, MODE_RST)
      `CHK(so_oe, 1'b0)
      `CHK(standby_o, 1'b0)
   endtask
   task automatic t_por_ignore();
      spr_host_model_inst.xfer(1'b0, 8'ha5);
      #1 `CHK(n_cmd, 0)
      `CHK(mode3_o, MODE_3)
   endtask
   task automatic t_power();
      @(posedge clk_sys);
      vcc_min_ok <= 1'b1;
      por_thresh_ok <= 1'b1;
      // Ready follows the 20 and 50 cycle waits plus two sync and one register stage
      repeat (22) @(posedge clk_sys);
      #1 `CHK(sel_ready_o, 1'b0)
      @(posedge clk_sys);
      #1 `CHK(sel_ready_o, 1'b1)
      `CHK(standby_o, 1'b1)
      `CHK(wr_ready_o, 1'b0)
      repeat (29) @(posedge clk_sys);
      #1 `CHK(wr_ready_o, 1'b0)
      @(posedge clk_sys);
      #1 `CHK(wr_ready_o, 1'b1)
   endtask
   task automatic t_mode();
      spr_host_model_inst.xfer(1'b0, 8'ha5);
      #1 `CHK(mode3_o, MODE_0)
      `CHK(cmd_op_o, 8'ha5)
      `CHK(n_cmd, 1)
      spr_host_model_inst.xfer(1'b1, 8'h5a);
      #1 `CHK(mode3_o, MODE_3)
      `CHK(cmd_op_o, 8'h5a)
   endtask
   task automatic t_output();
      @(posedge clk_sys);
      out_req <= 1'b1;
      out_bit <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 `CHK(so_oe, 1'b0)
      fork
         spr_host_model_inst.xfer(1'b1, 8'h3c);
         begin
            repeat (20) @(posedge clk_sys);
            #1 `CHK(so_oe, 1'b1)
            `CHK(so_o, 1'b1)
         end
      join
      #1 `CHK(so_oe, 1'b0)
      `CHK(n_cmd, 3)
      @(posedge clk_sys);
      out_req <= 1'b0;
   endtask
   task automatic t_rereset();
      spr_host_model_inst.xfer(1'b0, 8'hff);
      spr_host_model_inst.set_select(1'b0);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 `CHK(mode3_o, MODE_RST)
      `CHK(cmd_op_o, OP_RST)
      `CHK(standby_o, 1'b0)
      @(posedge clk_sys);
      rst_b <= 1'b1;
      out_req <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 `CHK(standby_o, 1'b1)
      `CHK(mode3_o, MODE_3)
      // Select held low through reset: clocks alone must not make an instruction
      spr_host_model_inst.shift_byte(8'h81);
      #1 `CHK(so_oe, 1'b0)
      spr_host_model_inst.set_select(1'b1);
      #1 `CHK(n_cmd, 4)
      spr_host_model_inst.xfer(1'b1, 8'h81);
      #1 `CHK(cmd_op_o, 8'h81)
      `CHK(n_cmd, 5)
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      #1 t_reset();
      t_por_ignore();
      t_power();
      t_mode();
      t_output();
      t_rereset();
      repeat (4) @(posedge clk_sys);
      results();
   end
endmodule
